// file: rtl/osc_select_defines.vh
`ifndef OSC_SELECT_DEFINES_VH
`define OSC_SELECT_DEFINES_VH

// ****************************************
// Clock rate
// ****************************************
`define MCLK_HZ            20000000

// ****************************************
// Oscillator frequencies in Hz
// ****************************************
`define FAST_RC_F0_HZ      910000
`define FAST_RC_F1_HZ      2000000
`define FAST_RC_F2_HZ      4000000
`define FAST_RC_F3_HZ      8000000
`define SLOW_RC_HZ         32000
`define SLOW_XTAL_MHZ      32768

// ****************************************
// Static option encodings
// ****************************************
`define FAST_SRC_EXT       1'b0
`define FAST_SRC_RC        1'b1
`define SLOW_SRC_XTAL      1'b0
`define SLOW_SRC_RC        1'b1

// ****************************************
// Register offsets and fields
// ****************************************
`define TIME_BASE_CTRL_OFFSET  8'h00
`define STAT_OFFSET        8'h01
`define TIME_BASE_LOWPWR_BIT   0
`define LOWPWR_RESET       1'b0
`define STAT_XTAL_RDY_BIT  0
`define STAT_FAST_RC_BIT   1
`define STAT_SLOW_RC_BIT   2
`define STAT_FILT_ON_BIT   3
`define STAT_FREQ_LSB      4
`define STAT_FREQ_MSB      5
`define STAT_SLOW_RDY_BIT  6

// ****************************************
// Start-up counts in crystal edges
// ****************************************
`define XTAL_START_QUICK   16'h0400
`define XTAL_START_LOWPWR  16'h2000

// ****************************************
// Pin slots of the shared pin vector
// ****************************************
`define PIN_SHARED_ZERO    0
`define PIN_SHARED_ONE     1
`define PIN_XTAL_A         2
`define PIN_XTAL_B         3
`define PIN_COUNT          4

`endif

// file: rtl/noise_filter.v
`timescale 1ns/1ps
`default_nettype none

module noise_filter (
  input  wire       mclk,
  input  wire       rst_n,
  input  wire       bypass,
  input  wire       rawIn,
  output reg        filtOut
);

  reg [2:0] hist_r;

  // ****************************************
  // Sample history and glitch rejection
  // ****************************************
  // Unless bypassed, output moves only after three equal samples
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hist_r  <= 3'h0;
      filtOut <= 1'b0;
    end else begin
      hist_r <= {hist_r[1:0], rawIn};
      if (bypass) begin
        filtOut <= rawIn;
      end else if (hist_r == 3'h7) begin
        filtOut <= 1'b1;
      end else if (hist_r == 3'h0) begin
        filtOut <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// file: rtl/rate_divider.v
`timescale 1ns/1ps
`default_nettype none

module rate_divider (
  input  wire       mclk,
  input  wire       rst_n,
  input  wire       run,
  input  wire [9:0] divisor,
  output reg        tick
);

  reg [9:0] count_r;

  // ****************************************
  // Down counter, one pulse per period
  // ****************************************
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= 10'h000;
      tick    <= 1'b0;
    end else if (!run) begin
      count_r <= 10'h000;
      tick    <= 1'b0;
    end else if (count_r == 10'h000) begin
      count_r <= divisor - 10'h001;
      tick    <= 1'b1;
    end else begin
      count_r <= count_r - 10'h001;
      tick    <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// file: rtl/osc_source_select.v
// Contract
// - External clock option drives fast clock from pin
// - External clock filter, bypassable by static option
// - Fast RC runs at four fixed rates
// - Fast RC frees both shared port pins
// - Option selects 32.768kHz crystal as slow source
// - Crystal start-up delay before clock is used
// - Unused crystal pins act as plain I/O
// - Control bit: 0 quick start, 1 low power
// - Power-on clears the crystal mode bit
// - Crystal clock runs whatever the mode bit
// - Option selects 32kHz RC as slow source
// - Slow source clocks watchdog and time base
// - Sleep gates system clock, slow clock stays
// - Exactly one fast and one slow source
`timescale 1ns/1ps
`default_nettype none
`include "osc_select_defines.vh"

module osc_source_select (
  input  wire                    mclk,
  input  wire                    rst_n,
  // Static options
  input  wire                    fastSrcSel,
  input  wire [1:0]              fastRcFreqSel,
  input  wire                    slowSrcSel,
  input  wire                    extFilterBypass,
  // System control
  input  wire                    useSlowSys,
  input  wire                    sleepReq,
  // Register port
  input  wire [7:0]              regAddr,
  input  wire [7:0]              regWrData,
  input  wire                    regWrStb,
  input  wire                    regRdStb,
  output reg  [7:0]              regRdData,
  // Shared pins, general I/O side
  input  wire [`PIN_COUNT-1:0]   gpioOut,
  input  wire [`PIN_COUNT-1:0]   gpioOe,
  output reg  [`PIN_COUNT-1:0]   gpioIn,
  // Shared pins, pad side
  input  wire [`PIN_COUNT-1:0]   padIn,
  output reg  [`PIN_COUNT-1:0]   padOut,
  output reg  [`PIN_COUNT-1:0]   padOe,
  // Clock enables
  output reg                     sysClkEn,
  output reg                     slowClkEn,
  output reg                     wdtClkEn,
  output reg                     timeBaseClkEn,
  output reg                     slowReady
);

  // ****************************************
  // Fast and slow RC divisors, rounded to nearest
  // ****************************************
  localparam integer DIV0_I = (`MCLK_HZ + `FAST_RC_F0_HZ / 2) / `FAST_RC_F0_HZ;
  localparam integer DIV1_I = (`MCLK_HZ + `FAST_RC_F1_HZ / 2) / `FAST_RC_F1_HZ;
  localparam integer DIV2_I = (`MCLK_HZ + `FAST_RC_F2_HZ / 2) / `FAST_RC_F2_HZ;
  localparam integer DIV3_I = (`MCLK_HZ + `FAST_RC_F3_HZ / 2) / `FAST_RC_F3_HZ;
  localparam integer DIVS_I = (`MCLK_HZ + `SLOW_RC_HZ / 2) / `SLOW_RC_HZ;
  localparam [9:0]   DIV0   = DIV0_I[9:0];
  localparam [9:0]   DIV1   = DIV1_I[9:0];
  localparam [9:0]   DIV2   = DIV2_I[9:0];
  localparam [9:0]   DIV3   = DIV3_I[9:0];
  localparam [9:0]   DIVS   = DIVS_I[9:0];

  // ****************************************
  // Declarations
  // ****************************************
  reg                   cfgDone_r;
  reg                   fastSrc_r;
  reg  [1:0]            freqSel_r;
  reg                   slowSrc_r;
  reg                   bypass_r;
  reg                   lowPower_r;
  reg  [`PIN_COUNT-1:0] padMeta_r;
  reg  [`PIN_COUNT-1:0] padSync_r;
  reg                   extPrev_r;
  reg                   xtalPrev_r;
  reg  [15:0]           xtalCount_r;
  reg  [15:0]           xtalCount_nxt;
  reg                   xtalReady_r;
  reg  [9:0]            fastDiv;
  reg  [7:0]            status;
  reg  [`PIN_COUNT-1:0] oscOwned;
  wire                  extFilt;
  wire                  fastRcTick;
  wire                  slowRcTick;
  wire                  extTick;
  wire                  xtalTick;
  wire                  fastTick;
  wire                  slowTick;
  wire                  xtalUsed;
  wire [15:0]           xtalTarget;

  // ****************************************
  // Static option capture
  // ****************************************
  // Options taken once, on first edge after reset
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfgDone_r <= 1'b0;
      fastSrc_r <= `FAST_SRC_RC;
      freqSel_r <= 2'h0;
      slowSrc_r <= `SLOW_SRC_RC;
      bypass_r  <= 1'b0;
    end else if (!cfgDone_r) begin
      cfgDone_r <= 1'b1;
      fastSrc_r <= fastSrcSel;
      freqSel_r <= fastRcFreqSel;
      slowSrc_r <= slowSrcSel;
      bypass_r  <= extFilterBypass;
    end
  end

  // ****************************************
  // Pad synchronisers
  // ****************************************
  // Two flops on every pad input
  genvar gi;
  generate
    for (gi = 0; gi < `PIN_COUNT; gi = gi + 1) begin : g_sync
      always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          padMeta_r[gi] <= 1'b0;
          padSync_r[gi] <= 1'b0;
        end else begin
          padMeta_r[gi] <= padIn[gi];
          padSync_r[gi] <= padMeta_r[gi];
        end
      end
    end
  endgenerate

  // ****************************************
  // External clock path
  // ****************************************
  noise_filter u_filter (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .bypass  (bypass_r),
    .rawIn   (padSync_r[`PIN_SHARED_ONE]),
    .filtOut (extFilt)
  );

  // Rising edge detect of filtered pin clock and unfiltered crystal pin
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      extPrev_r  <= 1'b0;
      xtalPrev_r <= 1'b0;
    end else begin
      extPrev_r  <= extFilt;
      xtalPrev_r <= padSync_r[`PIN_XTAL_A];
    end
  end

  assign extTick  = extFilt & ~extPrev_r;
  assign xtalTick = padSync_r[`PIN_XTAL_A] & ~xtalPrev_r & xtalUsed;

  // ****************************************
  // Internal RC oscillators
  // ****************************************
  // Divisor picked from the four fixed rates
  always @* begin
    case (freqSel_r)
      2'h0:    fastDiv = DIV0;
      2'h1:    fastDiv = DIV1;
      2'h2:    fastDiv = DIV2;
      2'h3:    fastDiv = DIV3;
      default: fastDiv = DIV0;
    endcase
  end

  rate_divider u_fast_rc (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .run     (cfgDone_r & (fastSrc_r == `FAST_SRC_RC)),
    .divisor (fastDiv),
    .tick    (fastRcTick)
  );

  rate_divider u_slow_rc (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .run     (cfgDone_r & (slowSrc_r == `SLOW_SRC_RC)),
    .divisor (DIVS),
    .tick    (slowRcTick)
  );

  // ****************************************
  // Source selection
  // ****************************************
  assign fastTick = cfgDone_r & ((fastSrc_r == `FAST_SRC_EXT) ? extTick : fastRcTick);
  assign slowTick = cfgDone_r & ((slowSrc_r == `SLOW_SRC_XTAL) ? xtalTick : slowRcTick);
  assign xtalUsed = cfgDone_r & (slowSrc_r == `SLOW_SRC_XTAL);

  // ****************************************
  // Crystal start-up timer
  // ****************************************
  // Low power mode stretches the start-up wait
  assign xtalTarget = lowPower_r ? `XTAL_START_LOWPWR : `XTAL_START_QUICK;

  always @* begin
    xtalCount_nxt = xtalCount_r;
    if (xtalTick && !xtalReady_r) begin
      xtalCount_nxt = xtalCount_r + 16'h0001;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      xtalCount_r <= 16'h0000;
      xtalReady_r <= 1'b0;
    end else begin
      xtalCount_r <= xtalCount_nxt;
      if (xtalUsed && xtalCount_nxt >= xtalTarget) begin
        xtalReady_r <= 1'b1;
      end
    end
  end

  // ****************************************
  // Clock enable outputs
  // ****************************************
  // Slow domain stays alive while system sleeps
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sysClkEn      <= 1'b0;
      slowClkEn     <= 1'b0;
      wdtClkEn      <= 1'b0;
      timeBaseClkEn <= 1'b0;
      slowReady     <= 1'b0;
    end else begin
      slowReady     <= (slowSrc_r == `SLOW_SRC_RC) ? cfgDone_r : xtalReady_r;
      slowClkEn     <= slowTick & slowReady;
      wdtClkEn      <= slowTick & slowReady;
      timeBaseClkEn <= slowTick & slowReady;
      if (sleepReq) begin
        sysClkEn <= 1'b0;
      end else if (useSlowSys) begin
        sysClkEn <= slowTick & slowReady;
      end else begin
        sysClkEn <= fastTick;
      end
    end
  end

  // ****************************************
  // Pin ownership
  // ****************************************
  // Oscillator keeps a pin only while its source uses it
  always @* begin
    oscOwned                   = {`PIN_COUNT{1'b0}};
    oscOwned[`PIN_SHARED_ONE]  = cfgDone_r & (fastSrc_r == `FAST_SRC_EXT);
    oscOwned[`PIN_SHARED_ZERO] = cfgDone_r & (fastSrc_r == `FAST_SRC_EXT);
    oscOwned[`PIN_XTAL_A]      = xtalUsed;
    oscOwned[`PIN_XTAL_B]      = xtalUsed;
  end

  // Owned pins are not driven; free pins follow I/O
  generate
    for (gi = 0; gi < `PIN_COUNT; gi = gi + 1) begin : g_pins
      always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          padOut[gi] <= 1'b0;
          padOe[gi]  <= 1'b0;
          gpioIn[gi] <= 1'b0;
        end else begin
          padOut[gi] <= gpioOut[gi] & ~oscOwned[gi];
          padOe[gi]  <= gpioOe[gi] & ~oscOwned[gi] & cfgDone_r;
          gpioIn[gi] <= padSync_r[gi] & ~oscOwned[gi];
        end
      end
    end
  endgenerate

  // ****************************************
  // Register file
  // ****************************************
  // Mode bit write; cleared on power-on
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lowPower_r <= `LOWPWR_RESET;
    end else if (regWrStb && regAddr == `TIME_BASE_CTRL_OFFSET) begin
      lowPower_r <= regWrData[`TIME_BASE_LOWPWR_BIT];
    end
  end

  // Status word assembly
  always @* begin
    status                            = 8'h00;
    status[`STAT_XTAL_RDY_BIT]        = xtalReady_r;
    status[`STAT_FAST_RC_BIT]         = fastSrc_r;
    status[`STAT_SLOW_RC_BIT]         = slowSrc_r;
    status[`STAT_FILT_ON_BIT]         = ~bypass_r;
    status[`STAT_FREQ_MSB:`STAT_FREQ_LSB] = freqSel_r;
    status[`STAT_SLOW_RDY_BIT]        = slowReady;
  end

  // Read data valid in the cycle after the strobe
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= 8'h00;
    end else if (regRdStb) begin
      case (regAddr)
        `TIME_BASE_CTRL_OFFSET: regRdData <= {7'h00, lowPower_r};
        `STAT_OFFSET: regRdData <= status;
        default:      regRdData <= 8'h00;
      endcase
    end else begin
      regRdData <= 8'h00;
    end
  end

endmodule

`default_nettype wire

// file: test/osc_select_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "osc_select_defines.vh"

module osc_select_props (
  input wire logic                  mclk,
  input wire logic                  rst_n,
  input wire logic                  fastSrcSel,
  input wire logic                  slowSrcSel,
  input wire logic                  sleepReq,
  input wire logic [7:0]            regAddr,
  input wire logic                  regRdStb,
  input wire logic [7:0]            regRdData,
  input wire logic [`PIN_COUNT-1:0] padOe,
  input wire logic                  sysClkEn,
  input wire logic                  slowClkEn,
  input wire logic                  wdtClkEn,
  input wire logic                  timeBaseClkEn,
  input wire logic                  slowReady
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sleep_gate_a: assert property (sleepReq && $past(sleepReq) |-> !sysClkEn)
    else $error("system enable while asleep");
  slow_wdt_a: assert property (wdtClkEn == slowClkEn)
    else $error("watchdog enable differs from slow enable");
  slow_tbase_a: assert property (timeBaseClkEn == slowClkEn)
    else $error("time base enable differs from slow enable");
  ready_gate_a: assert property (!slowReady |-> !slowClkEn)
    else $error("slow enable before ready");
  ready_hold_a: assert property (slowReady |=> slowReady)
    else $error("ready dropped");
  pulse_width_a: assert property (sysClkEn |=> !sysClkEn)
    else $error("system enable longer than one cycle");
  mode_read_a: assert property ($past(regRdStb) && $past(regAddr) == 8'h00
    |-> regRdData[7:1] == 7'h00)
    else $error("mode register upper bits not zero");
  read_idle_a: assert property (!$past(regRdStb) |-> regRdData == 8'h00)
    else $error("read data outside its cycle");
  ext_pins_a: assert property (!fastSrcSel |-> padOe[1:0] == 2'h0)
    else $error("external clock pins driven");
  xtal_pins_a: assert property (!slowSrcSel |-> padOe[3:2] == 2'h0)
    else $error("crystal pins driven");
endmodule

bind osc_source_select osc_select_props i_props (
  .mclk(mclk), .rst_n(rst_n), .fastSrcSel(fastSrcSel), .slowSrcSel(slowSrcSel),
  .sleepReq(sleepReq), .regAddr(regAddr), .regRdStb(regRdStb), .regRdData(regRdData),
  .padOe(padOe), .sysClkEn(sysClkEn), .slowClkEn(slowClkEn), .wdtClkEn(wdtClkEn),
  .timeBaseClkEn(timeBaseClkEn), .slowReady(slowReady)
);
`default_nettype wire

// file: test/osc_partner.sv
`timescale 1ns/1ps
`default_nettype none

module osc_partner (
  input wire logic  mclk,
  input wire logic  extRun,
  input wire logic  xtalRun,
  input wire logic  glitch,
  output var logic  extClk,
  output var logic  xtalClk
);
  logic [3:0] extCnt = 4'h0;
  logic [1:0] xCnt   = 2'h0;

  // External clock, period 10 cycles; a glitch only when stopped
  always @(posedge mclk) begin
    extCnt <= (extCnt == 4'h4) ? 4'h0 : extCnt + 4'h1;
    if (!extRun)
      extClk <= glitch;
    else if (extCnt == 4'h4)
      extClk <= ~extClk;
  end

  // Crystal, compressed to period 4 cycles; low when stopped
  always @(posedge mclk) begin
    xCnt <= xCnt + 2'h1;
    if (!xtalRun)
      xtalClk <= 1'b0;
    else if (xCnt[0])
      xtalClk <= ~xtalClk;
  end
endmodule
`default_nettype wire

// file: test/osc_source_select_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "osc_select_defines.vh"

module osc_source_select_bench;
  logic       mclk = 0, rst_n = 0, fastSel = 1, slowSel = 1, byp = 0, useSlow = 0;
  logic       sleep = 0, wr = 0, rd = 0, extRun = 0, xtalRun = 0, glitch = 0;
  logic [1:0] freq = 2'h0;
  logic [7:0] addr = 8'h00, wdat = 8'h00, rdat, d, r;
  logic [3:0] gOut = 4'h0, gOe = 4'h0, padR = 4'h0, gIn, pOut, pOe;
  logic       sysEn, slowEn, wdtEn, tbEn, rdy, extClk, xtalClk;
  wire  [3:0] padIn = {padR[3], slowSel ? padR[2] : xtalClk, fastSel ? padR[1] : extClk, padR[0]};
  integer     seed = 30, miscompares = 0, checked = 0, cyc = 0, sc, lc, tc, n, i;

  osc_source_select i_dut (
    .mclk(mclk), .rst_n(rst_n), .fastSrcSel(fastSel), .fastRcFreqSel(freq),
    .slowSrcSel(slowSel), .extFilterBypass(byp), .useSlowSys(useSlow), .sleepReq(sleep),
    .regAddr(addr), .regWrData(wdat), .regWrStb(wr), .regRdStb(rd), .regRdData(rdat),
    .gpioOut(gOut), .gpioOe(gOe), .gpioIn(gIn), .padIn(padIn), .padOut(pOut), .padOe(pOe),
    .sysClkEn(sysEn), .slowClkEn(slowEn), .wdtClkEn(wdtEn), .timeBaseClkEn(tbEn),
    .slowReady(rdy)
  );

  osc_partner i_partner (
    .mclk(mclk), .extRun(extRun), .xtalRun(xtalRun), .glitch(glitch),
    .extClk(extClk), .xtalClk(xtalClk)
  );

  // ****************************************
  // Clock, timeout and helpers
  // ****************************************
  initial begin
    forever #25 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 70000) begin
      miscompares = miscompares + 1;
      summarize;
    end
  end

  task summarize;
    if (miscompares == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task check(input logic [15:0] got, input logic [15:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      miscompares = miscompares + 1;
    end
  endtask

  // Count within one pulse of the expected figure
  task near(input integer got, input integer exp);
    check((got >= exp - 1 && got <= exp + 1) ? exp : got, exp);
  endtask

  function integer rcDiv(input logic [1:0] q);
    rcDiv = (q == 2'h0) ? 22 : (q == 2'h1) ? 10 : (q == 2'h2) ? 5 : 3;
  endfunction

  task boot(input logic f, input logic [1:0] q, input logic s, input logic b);
    rst_n <= 1'b0;
    fastSel <= f;
    freq <= q;
    slowSel <= s;
    byp <= b;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
  endtask

  task wrReg(input logic [7:0] a, input logic [7:0] v);
    addr <= a;
    wdat <= v;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task rdReg(input logic [7:0] a);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdat;
    @(posedge mclk);
  endtask

  task count(input integer w);
    sc = 0;
    lc = 0;
    tc = 0;
    repeat (w) begin
      @(posedge mclk);
      #1 sc = sc + sysEn;
      lc = lc + slowEn;
      tc = tc + wdtEn + tbEn;
    end
    @(posedge mclk);
  endtask

  task waitRdy(input integer lim);
    n = 0;
    while (!rdy && n < lim) begin
      @(posedge mclk);
      #1 n = n + 1;
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    // Fast RC at every rate, slow RC, pins free
    for (i = 0; i < 4; i = i + 1) begin
      boot(1'b1, i[1:0], 1'b1, $random(seed));
      gOe <= $random(seed);
      gOut <= $random(seed);
      padR <= $random(seed);
      rdReg(8'h01);
      check(d & 8'h36, {2'h0, freq, 1'b0, 1'b1, 1'b1, 1'b0});
      rdReg(8'h00);
      check(d, 8'h00);
      rdReg(8'h02 + {$random(seed)} % 8'hFD);
      check(d, 8'h00);
      check({pOe, pOut, gIn}, {gOe, gOut, padR});
      count(660);
      near(sc, 660 / rcDiv(freq));
      check(lc > 0, 1);
      r = $random(seed);
      wrReg(8'h00, r);
      rdReg(8'h00);
      check(d, {7'h00, r[0]});
      sleep <= 1'b1;
      count(1300);
      check(sc, 0);
      check(lc > 1, 1);
      sleep <= 1'b0;
      useSlow <= 1'b1;
      count(1300);
      near(sc, 1300 / 625);
      check(sc, lc);
      useSlow <= 1'b0;
    end
    // External clock, filtered then bypassed, with a glitch
    gOe <= 4'hF;
    gOut <= 4'hF;
    for (i = 0; i < 2; i = i + 1) begin
      boot(1'b0, $random(seed), 1'b1, i[0]);
      extRun <= 1'b1;
      repeat (20) @(posedge mclk);
      count(400);
      near(sc, 40);
      check({pOe[1:0], gIn[1:0]}, 4'h0);
      rdReg(8'h01);
      check(d & 8'h0F, {~byp, 3'h4});
      extRun <= 1'b0;
      repeat (20) @(posedge mclk);
      glitch <= 1'b1;
      @(posedge mclk);
      glitch <= 1'b0;
      count(20);
      check(sc, i);
    end
    // Crystal, quick start
    boot(1'b1, 2'h3, 1'b0, 1'b0);
    xtalRun <= 1'b1;
    waitRdy(4000);
    check(rdy, 1'b0);
    waitRdy(400);
    check(rdy, 1'b1);
    check({pOe[3:2], gIn[3:2]}, 4'h0);
    count(400);
    near(lc, 100);
    check(tc, 2 * lc);
    rdReg(8'h01);
    check(d, 8'h7B);
    wrReg(8'h00, 8'h01);
    count(400);
    near(lc, 100);
    // Crystal, low power from the start
    xtalRun <= 1'b0;
    boot(1'b1, 2'h3, 1'b0, 1'b0);
    wrReg(8'h00, 8'h01);
    xtalRun <= 1'b1;
    waitRdy(32000);
    check(rdy, 1'b0);
    waitRdy(1000);
    check(rdy, 1'b1);
    summarize;
  end
endmodule
`default_nettype wire
